// file: dv/cycle_ctrl_props.sv
// port checker for the cycle controller
`timescale 1ns/1ps
module cycle_ctrl_props #(
  parameter int MAX_DUTY = 25,
  parameter int RESTART_QUAL = 50
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic current_limit_hit,
  input wire logic surge_detect,
  input wire logic output_restart_low,
  input wire logic rect_below_threshold,
  input wire logic power_switch_on,
  input wire logic sync_rectifier_drive,
  input wire logic [3:0] current_limit_sel,
  input wire logic cycle_request,
  input wire logic control_relinquish
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] on_q;
  logic [15:0] low_q;
  // run lengths taken on raw ports, so sync delay only adds slack
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      on_q <= 16'h0000;
    end else begin
      on_q <= power_switch_on ? on_q + 16'h0001 : 16'h0000;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= output_restart_low ? low_q + 16'h0001 : 16'h0000;
    end
  end
  req_then_on_a: assert property (cycle_request |=> power_switch_on)
    else $error("switch not on after request");
  duty_bound_a: assert property (on_q <= 16'(MAX_DUTY))
    else $error("switch on past max duty");
  no_abort_a: assert property ($fell(power_switch_on) |-> on_q >= 16'(MAX_DUTY) ||
    $past(current_limit_hit, 2) || $past(current_limit_hit, 3) || $past(current_limit_hit, 4))
    else $error("switch cycle cut short");
  rect_surge_a: assert property (surge_detect [*5] |-> !sync_rectifier_drive)
    else $error("rectifier driven during surge");
  rect_drop_a: assert property ($rose(rect_below_threshold) ##1 rect_below_threshold [*4] |->
    !sync_rectifier_drive)
    else $error("rectifier held after low drop");
  rect_prereq_a: assert property (cycle_request |-> !sync_rectifier_drive)
    else $error("rectifier on at request");
  limit_step_a: assert property ($onehot(current_limit_sel) &&
    (current_limit_sel == $past(current_limit_sel) ||
    current_limit_sel == $past(current_limit_sel) << 1 || current_limit_sel == $past(current_limit_sel) >> 1))
    else $error("limit level jumped");
  relinquish_qual_a: assert property ($rose(control_relinquish) |-> low_q >= 16'(RESTART_QUAL))
    else $error("relinquished before qualification");
endmodule : cycle_ctrl_props
bind cycle_ctrl cycle_ctrl_props #(.MAX_DUTY(MAX_DUTY), .RESTART_QUAL(RESTART_QUAL)) props (.ref_clk, .rstn,
  .current_limit_hit, .surge_detect, .output_restart_low, .rect_below_threshold, .power_switch_on,
  .sync_rectifier_drive, .current_limit_sel, .cycle_request, .control_relinquish);

// file: dv/power_stage_model.sv
// power stage stand-in: ramps primary current, reports the forward edge
`timescale 1ns/1ps
module power_stage_model (
  input wire logic ref_clk,
  input wire logic power_switch_on,
  input wire logic [7:0] ramp,
  input wire logic mute,
  output logic current_limit_hit,
  output logic forward_sense
);
  int cnt = 0;
  initial begin
    current_limit_hit = 1'b0;
    forward_sense = 1'b0;
  end
  // ramp of zero never reaches the limit, so max duty ends the cycle
  always @(posedge ref_clk) begin
    #1;
    cnt = power_switch_on ? cnt + 1 : 0;
    current_limit_hit = ramp != 8'h00 && cnt >= int'(ramp);
    forward_sense = power_switch_on && !mute;
  end
endmodule : power_stage_model

// file: dv/tb_on_off_switch_cycle_control.sv
// self-checking bench for the cycle controller
`timescale 1ns/1ps
module tb_on_off_switch_cycle_control;
  localparam int CL = 40;
  localparam int MD = 25;
  localparam int RQ = 50;
  typedef struct {logic fb; int n; logic [3:0] sel; int reqs;} row_t;
  row_t rows [3] = '{'{1'b1, 12, cycle_ctrl_pkg::LIM_MAX, 12}, '{1'b0, 12, cycle_ctrl_pkg::LIM_LOW, 0},
    '{1'b1, 12, cycle_ctrl_pkg::LIM_MAX, 12}};
  logic ref_clk, rstn = 1'b0, feedback_low = 1'b0, surge_detect = 1'b0, output_current_sense = 1'b0;
  logic output_restart_low = 1'b0, rect_below_threshold = 1'b0, above_power_knee = 1'b0, mute = 1'b0;
  logic [7:0] ramp = 8'h05;
  logic current_limit_hit, forward_sense, power_switch_on, sync_rectifier_drive, cycle_request;
  logic control_relinquish, handshake_restart, constant_current_regulation, constant_power_active;
  logic [3:0] current_limit_sel;
  int fail_count = 0, checked = 0, req_n = 0, on_n = 0, hs_n = 0, rect_n = 0;
  cycle_ctrl #(.CYCLE_LEN(CL), .MAX_DUTY(MD), .RESTART_QUAL(RQ)) dut (.ref_clk, .rstn, .feedback_low,
    .current_limit_hit, .forward_sense, .output_current_sense, .surge_detect, .output_restart_low,
    .rect_below_threshold, .above_power_knee, .power_switch_on, .sync_rectifier_drive, .current_limit_sel,
    .cycle_request, .control_relinquish, .handshake_restart, .constant_current_regulation,
    .constant_power_active);
  power_stage_model stage (.ref_clk, .power_switch_on, .ramp, .mute, .current_limit_hit, .forward_sense);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // bounded so a dead output cannot hang the run; looks just after the edge, once outputs have settled
  task automatic wait_hi(input logic rect);
    int k;
    k = 0;
    while ((rect ? sync_rectifier_drive : cycle_request) !== 1'b1 && k < 3 * CL) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask : wait_hi
  task automatic test_done;
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    req_n += int'(cycle_request === 1'b1);
    on_n += int'(power_switch_on === 1'b1);
    hs_n += int'(handshake_restart === 1'b1);
    rect_n += int'(sync_rectifier_drive === 1'b1);
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done;
  end
  initial begin
    tick(12);
    check({power_switch_on, sync_rectifier_drive, control_relinquish, handshake_restart,
      constant_current_regulation, constant_power_active, current_limit_sel}, {6'h00, 4'h8});
    rstn = 1'b1;
    foreach (rows[i]) begin
      feedback_low = rows[i].fb;
      tick(2 * CL);
      req_n = 0;
      tick(rows[i].n * CL);
      check(req_n, rows[i].reqs);
      check(current_limit_sel, rows[i].sel);
    end
    ramp = 8'h00;
    wait_hi(1'b0);
    on_n = 0;
    tick(4 * CL);
    check(on_n, 4 * MD);
    ramp = 8'h05;
    wait_hi(1'b0);
    on_n = 0;
    tick(4 * CL);
    check(on_n < 4 * MD, 1'b1);
    rect_n = 0;
    tick(4 * CL);
    check(rect_n > 0, 1'b1);
    surge_detect = 1'b1;
    tick(CL);
    rect_n = 0;
    tick(4 * CL);
    check(rect_n, 0);
    surge_detect = 1'b0;
    wait_hi(1'b1);
    check(sync_rectifier_drive, 1'b1);
    rect_below_threshold = 1'b1;
    tick(5);
    check(sync_rectifier_drive, 1'b0);
    rect_below_threshold = 1'b0;
    output_current_sense = 1'b1;
    above_power_knee = 1'b1;
    tick(CL);
    req_n = 0;
    tick(8 * CL);
    check(constant_power_active, 1'b1);
    check(req_n < 8, 1'b1);
    above_power_knee = 1'b0;
    tick(CL);
    check(constant_current_regulation, 1'b1);
    output_current_sense = 1'b0;
    mute = 1'b1;
    hs_n = 0;
    tick(8 * CL);
    check(hs_n > 0, 1'b1);
    mute = 1'b0;
    tick(2 * CL);
    repeat (2) begin
      output_restart_low = 1'b1;
      tick(RQ - 10);
      output_restart_low = 1'b0;
      tick(1);
    end
    check(control_relinquish, 1'b0);
    output_restart_low = 1'b1;
    tick(RQ + 10);
    check(control_relinquish, 1'b1);
    req_n = 0;
    tick(2 * CL);
    check(req_n, 0);
    test_done;
  end
endmodule : tb_on_off_switch_cycle_control

// file: hw/cmp_sync.sv
// two-flop synchronisers for every comparator input
`timescale 1ns/1ps
module cmp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] raw,
  cmp_sync_if.src sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  initial begin
    if (WIDTH != 8) $error("cmp_sync width must be 8");
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  assign sync.fb_low = sync_q[0];
  assign sync.cur_lim = sync_q[1];
  assign sync.forward_sense = sync_q[2];
  assign sync.output_current_sense = sync_q[3];
  assign sync.surge = sync_q[4];
  assign sync.out_low = sync_q[5];
  assign sync.rect_release = sync_q[6];
  assign sync.knee_above = sync_q[7];
endmodule : cmp_sync

// file: hw/cmp_sync_if.sv
// synchronised comparator levels passed from the synchroniser to the controller
`timescale 1ns/1ps
interface cmp_sync_if;
  logic fb_low;
  logic cur_lim;
  logic forward_sense;
  logic output_current_sense;
  logic surge;
  logic out_low;
  logic rect_release;
  logic knee_above;
  modport src (output fb_low, cur_lim, forward_sense, output_current_sense, surge, out_low, rect_release, knee_above);
  modport dst (input fb_low, cur_lim, forward_sense, output_current_sense, surge, out_low, rect_release, knee_above);
endinterface : cmp_sync_if

// file: hw/cycle_ctrl.sv
// on/off switching cycle controller with current-limit state machine
`timescale 1ns/1ps
`include "cycle_ctrl_defs.svh"
// Overview of operation
// - free-running clock; each cycle start samples feedback and decides to switch.
// - current-limit level chosen from history of request decisions (want) at cycle start.
// - four current-limit states, each with its own level.
// - heavy load climbs to top level; skipped cycles step it down.
// - switch on at cycle start, off at current limit or max duty.
// - a launched cycle always completes; later samples never abort it.
// - rectifier drive only after a requested cycle and a forward falling edge.
// - surge above about three times threshold inhibits rectifier drive until nominal.
// - continuous mode releases rectifier drive just before next request.
// - discontinuous mode releases rectifier drive on low drop comparator.
// - output low beyond qualification time relinquishes control, ending regulation.
// - output current comparator trip reduces requested pulses for constant current.
// - constant current below 5 V, constant power above knee threshold.
// - below about 3 V output, auto-restart repeats until load drops.
// - six unanswered requests or six unrequested cycles restart the handshake.
// - decision cycle rate is the 100 kHz oscillator.
module cycle_ctrl #(
  parameter int CYCLE_LEN = `CYCLE_LEN_CYC,
  parameter int MAX_DUTY = `MAX_DUTY_CYC,
  parameter int RESTART_QUAL = `RESTART_QUAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic feedback_low,
  input wire logic current_limit_hit,
  input wire logic forward_sense,
  input wire logic output_current_sense,
  input wire logic surge_detect,
  input wire logic output_restart_low,
  input wire logic rect_below_threshold,
  input wire logic above_power_knee,
  output logic power_switch_on,
  output logic sync_rectifier_drive,
  output logic [3:0] current_limit_sel,
  output logic cycle_request,
  output logic control_relinquish,
  output logic handshake_restart,
  output logic constant_current_regulation,
  output logic constant_power_active
);
  initial begin
    if (CYCLE_LEN < 4) $error("cycle length too short");
    if (MAX_DUTY < 1 || MAX_DUTY >= CYCLE_LEN) $error("max duty out of range");
    if (RESTART_QUAL < 1) $error("restart qualification too short");
  end

  cmp_sync_if cs ();
  cmp_sync #(.WIDTH(8)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .raw({above_power_knee, rect_below_threshold, output_restart_low, surge_detect,
          output_current_sense, forward_sense, current_limit_hit, feedback_low}),
    .sync(cs.src)
  );

  function automatic logic [3:0] count_ones(input logic [`HIST_LEN-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `HIST_LEN; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction : count_ones

  // oscillator: cycle phase counter, never stops
  logic [$clog2(CYCLE_LEN)-1:0] phase_q;
  logic cycle_start;
  assign cycle_start = (phase_q == '0);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) phase_q <= '0;
    else if (phase_q == ($clog2(CYCLE_LEN))'(CYCLE_LEN - 1)) phase_q <= '0;
    else phase_q <= phase_q + 1'b1;
  end

  // regulation: constant current skips requests while current trips
  logic [1:0] skip_q;
  logic cur_trip;
  logic cp_skip;
  assign cur_trip = cs.output_current_sense && !cs.knee_above;
  assign cp_skip = cs.output_current_sense && cs.knee_above && (skip_q != 2'h0);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) skip_q <= 2'h0;
    else if (cycle_start) skip_q <= (skip_q == 2'(`CP_SKIP_DIV - 1)) ? 2'h0 : skip_q + 2'h1;
  end
  logic want;
  assign want = cs.fb_low && !cur_trip && !cp_skip && !control_relinquish;

  // switch cycle state machine
  cycle_ctrl_pkg::sw_state_t sw_q;
  logic [$clog2(CYCLE_LEN)-1:0] on_cnt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_q <= cycle_ctrl_pkg::SW_IDLE;
      on_cnt_q <= '0;
    end else begin
      unique case (sw_q)
        cycle_ctrl_pkg::SW_IDLE: begin
          if (cycle_start && want) begin
            sw_q <= cycle_ctrl_pkg::SW_ON;
            on_cnt_q <= '0;
          end
        end
        cycle_ctrl_pkg::SW_ON: begin
          // feedback is not looked at here, so a cycle cannot be aborted
          on_cnt_q <= on_cnt_q + 1'b1;
          if (cs.cur_lim || on_cnt_q == ($clog2(CYCLE_LEN))'(MAX_DUTY - 1)) begin
            sw_q <= cycle_ctrl_pkg::SW_WAIT;
          end
        end
        cycle_ctrl_pkg::SW_WAIT: begin
          if (phase_q == ($clog2(CYCLE_LEN))'(CYCLE_LEN - 1)) sw_q <= cycle_ctrl_pkg::SW_IDLE;
        end
        default: sw_q <= cycle_ctrl_pkg::SW_IDLE;
      endcase
    end
  end
  assign power_switch_on = (sw_q == cycle_ctrl_pkg::SW_ON);
  assign cycle_request = cycle_start && want && (sw_q == cycle_ctrl_pkg::SW_IDLE);

  // load history and current-limit state machine
  logic [`HIST_LEN-1:0] hist_q;
  logic [3:0] ones;
  assign ones = count_ones(hist_q);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) hist_q <= '0;
    else if (control_relinquish) hist_q <= '0;
    else if (cycle_start) hist_q <= {hist_q[`HIST_LEN-2:0], want};
  end
  cycle_ctrl_pkg::limit_state_t lim_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) lim_q <= cycle_ctrl_pkg::LIM_MAX;
    else if (cycle_start) begin
      unique case (lim_q)
        cycle_ctrl_pkg::LIM_LOW:
          if (ones >= 4'(`HIST_UP_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_MED;
        cycle_ctrl_pkg::LIM_MED:
          if (ones >= 4'(`HIST_UP_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_HIGH;
          else if (ones <= 4'(`HIST_DOWN_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_LOW;
        cycle_ctrl_pkg::LIM_HIGH:
          if (ones >= 4'(`HIST_UP_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_MAX;
          else if (ones <= 4'(`HIST_DOWN_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_MED;
        cycle_ctrl_pkg::LIM_MAX:
          if (ones <= 4'(`HIST_DOWN_THRESH)) lim_q <= cycle_ctrl_pkg::LIM_HIGH;
        default: lim_q <= cycle_ctrl_pkg::LIM_MAX;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) current_limit_sel <= cycle_ctrl_pkg::LIM_MAX;
    else current_limit_sel <= lim_q;
  end

  // handshake watchdog: unanswered requests, or switching with no request
  logic [2:0] noans_q;
  logic [2:0] unreq_q;
  logic req_pend_q;
  logic forward_d1_q;
  logic forward_fall;
  assign forward_fall = forward_d1_q && !cs.forward_sense;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) forward_d1_q <= 1'b0;
    else forward_d1_q <= cs.forward_sense;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      noans_q <= 3'h0;
      unreq_q <= 3'h0;
      req_pend_q <= 1'b0;
    end else if (handshake_restart) begin
      noans_q <= 3'h0;
      unreq_q <= 3'h0;
      req_pend_q <= 1'b0;
    end else begin
      if (cycle_request) req_pend_q <= 1'b1;
      else if (forward_fall) req_pend_q <= 1'b0;
      if (cycle_start) begin
        if (req_pend_q && !forward_fall) noans_q <= noans_q + 3'h1;
        else noans_q <= 3'h0;
      end
      if (forward_fall && !req_pend_q) unreq_q <= unreq_q + 3'h1;
      else if (forward_fall) unreq_q <= 3'h0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) handshake_restart <= 1'b0;
    else handshake_restart <= !handshake_restart &&
      (noans_q >= 3'(`HANDSHAKE_MISS_CYCLES) || unreq_q >= 3'(`HANDSHAKE_MISS_CYCLES));
  end

  // sync rectifier drive
  logic rect_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rect_q <= 1'b0;
    else if (cs.surge) rect_q <= 1'b0;
    else if (phase_q == ($clog2(CYCLE_LEN))'(CYCLE_LEN - 1) && want) rect_q <= 1'b0;
    else if (rect_q && cs.rect_release) rect_q <= 1'b0;
    else if (forward_fall && req_pend_q) rect_q <= 1'b1;
  end
  assign sync_rectifier_drive = rect_q;

  // auto-restart qualification on low output
  logic [$clog2(RESTART_QUAL+1)-1:0] qual_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) qual_q <= '0;
    else if (!cs.out_low) qual_q <= '0;
    else if (qual_q != ($clog2(RESTART_QUAL+1))'(RESTART_QUAL)) qual_q <= qual_q + 1'b1;
  end
  // relinquish holds while output stays low so restart repeats until load drops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) control_relinquish <= 1'b0;
    else control_relinquish <= (qual_q == ($clog2(RESTART_QUAL+1))'(RESTART_QUAL));
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      constant_current_regulation <= 1'b0;
      constant_power_active <= 1'b0;
    end else begin
      constant_current_regulation <= cur_trip && !control_relinquish;
      constant_power_active <= cs.output_current_sense && cs.knee_above && !control_relinquish;
    end
  end
endmodule : cycle_ctrl

// file: hw/cycle_ctrl_defs.svh
// timing and threshold constants for the on/off cycle controller
`ifndef CYCLE_CTRL_DEFS_SVH
`define CYCLE_CTRL_DEFS_SVH
`define CLK_FREQ_HZ 100000000
`define OSC_FREQ_HZ 100000
`define CYCLE_LEN_CYC (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define MAX_DUTY_PCT 64
`define MAX_DUTY_CYC ((`CYCLE_LEN_CYC * `MAX_DUTY_PCT) / 100)
`define HANDSHAKE_MISS_CYCLES 6
`define RESTART_QUAL_US 1000
`define RESTART_QUAL_CYC ((`RESTART_QUAL_US * (`CLK_FREQ_HZ / 1000000)))
`define HIST_LEN 8
`define HIST_UP_THRESH 6
`define HIST_DOWN_THRESH 2
`define CP_SKIP_DIV 2
`endif

// file: hw/cycle_ctrl_pkg.sv
// types for the on/off cycle controller
package cycle_ctrl_pkg;
  typedef enum logic [3:0] {
    LIM_LOW = 4'h1,
    LIM_MED = 4'h2,
    LIM_HIGH = 4'h4,
    LIM_MAX = 4'h8
  } limit_state_t;
  typedef enum logic [2:0] {
    SW_IDLE = 3'h1,
    SW_ON = 3'h2,
    SW_WAIT = 3'h4
  } sw_state_t;
endpackage : cycle_ctrl_pkg
